// [src/cws_shifter.sv]
// clocked word shifter with AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cws_shifter
	import cws_pkg::*;
#(
	parameter int unsigned BIT_CYC_SLOW = BIT_CYC_1K
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             link_clk_o,
	input  wire logic        link_data_i,
	output logic             link_data_o,
	output logic             link_data_oe
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	cws_state_t  state_q;
	logic        aw_full_q;
	logic        w_full_q;
	logic [4:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [4:0]  cfg_bits_q;
	logic        cfg_fall_q;
	logic        cfg_init_q;
	logic [4:0]  cfg_rate_q;
	logic [15:0] txd_q;
	logic [15:0] rxd_q;
	logic        done_q;
	logic        send_q;
	logic        used_q;
	logic [4:0]  xfer_bits_q;
	logic [4:0]  bit_no_q;
	logic [15:0] tx_sh_q;
	logic [15:0] rx_sh_q;
	logic [15:0] per_q;
	logic        sclk_q;
	logic        sdo_q;
	logic        oe_q;
	logic        sdi_s1_q;
	logic        sdi_s2_q;

	// ----------------------------------------
	// byte-lane merge
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire        busy_w   = (state_q == ST_SHIFT);
	wire        wr_en    = aw_full_q && w_full_q && !bvalid_q;
	wire        rd_en    = s_axi_arvalid && !rvalid_q;
	wire        wr_ctrl  = wr_en && (waddr_q == OFS_CTRL);
	wire        wr_cfg   = wr_en && (waddr_q == OFS_CFG);
	wire        wr_txd   = wr_en && (waddr_q == OFS_TXD);
	wire        wr_stat  = wr_en && (waddr_q == OFS_STAT);
	wire        wr_ok    = wr_ctrl || wr_cfg || wr_txd || wr_stat || (waddr_q == OFS_RXD);
	wire [31:0] cfg_word = {11'h000, cfg_rate_q, 6'h00, cfg_init_q, cfg_fall_q, 3'h0,
		cfg_bits_q};
	wire [31:0] cfg_new  = merge(cfg_word, wdata_q, wstrb_q);
	wire [31:0] txd_new  = merge({16'h0000, txd_q}, wdata_q, wstrb_q);
	wire [4:0]  new_bits = cfg_new[CFG_BITS_LSB +: 5];
	wire [4:0]  new_rate = cfg_new[CFG_RATE_LSB +: 5];
	wire        rate_ok  = (new_rate == RATE_1K) || (new_rate == RATE_10K) ||
		(new_rate == RATE_15K);
	wire [31:0] rd_word  =
		(s_axi_araddr == OFS_CTRL) ? {31'h0, send_q} << CTRL_SEND :
		(s_axi_araddr == OFS_CFG)  ? cfg_word :
		(s_axi_araddr == OFS_TXD)  ? {16'h0000, txd_q} :
		(s_axi_araddr == OFS_RXD)  ? {16'h0000, rxd_q} :
		(s_axi_araddr == OFS_STAT) ? {30'h0, done_q, busy_w} : 32'h0;
	wire        rd_ok    = (s_axi_araddr == OFS_CTRL) || (s_axi_araddr == OFS_CFG) ||
		(s_axi_araddr == OFS_TXD) || (s_axi_araddr == OFS_RXD) ||
		(s_axi_araddr == OFS_STAT);

	assign s_axi_awready = !aw_full_q && !bvalid_q;
	assign s_axi_wready  = !w_full_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ----------------------------------------
	// transfer setup
	// ----------------------------------------
	wire [4:0]  ovr_bits = wdata_q[CTRL_OVR_LSB +: 5];
	wire        start_w  = wr_ctrl && wstrb_q[0] && wdata_q[CTRL_GO] && !busy_w;
	wire [4:0]  req_bits = (wstrb_q[1] && wdata_q[CTRL_OVR_EN] && ovr_bits != 5'h00) ?
		ovr_bits : cfg_bits_q;
	wire [4:0]  pad_sh   = (req_bits < WORD_BITS) ? WORD_BITS - req_bits : 5'h00;
	wire [15:0] tx_ld    = txd_q << pad_sh;
	wire        inact    = cfg_fall_q;
	wire [15:0] per_w    = (cfg_rate_q == RATE_1K)  ? BIT_CYC_SLOW[15:0] :
		(cfg_rate_q == RATE_10K) ? BIT_CYC_10K[15:0] : BIT_CYC_15K[15:0];
	wire        edge_p;
	wire        end_p;
	wire        last_w   = (bit_no_q == xfer_bits_q - 5'h01);

	cws_bit_timer u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run      (busy_w),
		.period   (per_q),
		.edge_at  (SETUP_CYC[15:0]),
		.edge_p   (edge_p),
		.end_p    (end_p)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			waddr_q   <= 5'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				waddr_q   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVE;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= RESP_OKAY;
		end else if (rd_en) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVE;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// settings
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_bits_q <= BITS_RST;
			cfg_fall_q <= FALL_RST;
			cfg_init_q <= INIT_RST;
			cfg_rate_q <= RATE_RST;
			txd_q      <= 16'h0000;
		end else begin
			if (wr_cfg) begin
				if (new_bits != 5'h00) begin
					cfg_bits_q <= new_bits;
				end
				cfg_fall_q <= cfg_new[CFG_FALL];
				cfg_init_q <= cfg_new[CFG_INIT];
				if (rate_ok) begin
					cfg_rate_q <= new_rate;
				end
			end
			if (wr_txd) begin
				txd_q <= txd_new[15:0];
			end
		end
	end

	// ----------------------------------------
	// status
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		// done after final bit, set wins
		end else if (busy_w && end_p && last_w) begin
			done_q <= 1'b1;
		end else if (start_w || (wr_stat && wstrb_q[0] && wdata_q[STAT_DONE])) begin
			done_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// data line synchroniser
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
		end else begin
			sdi_s1_q <= link_data_i;
			sdi_s2_q <= sdi_s1_q;
		end
	end

	// ----------------------------------------
	// shift engine
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q     <= ST_IDLE;
			send_q      <= 1'b0;
			used_q      <= 1'b0;
			xfer_bits_q <= BITS_RST;
			bit_no_q    <= 5'h00;
			tx_sh_q     <= 16'h0000;
			rx_sh_q     <= 16'h0000;
			rxd_q       <= 16'h0000;
			per_q       <= BIT_CYC_15K[15:0];
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_w) begin
						state_q     <= ST_SHIFT;
						send_q      <= wdata_q[CTRL_SEND];
						used_q      <= 1'b1;
						xfer_bits_q <= req_bits;
						bit_no_q    <= 5'h00;
						tx_sh_q     <= tx_ld;
						rx_sh_q     <= 16'h0000;
						per_q       <= per_w;
					end
				end
				ST_SHIFT: begin
					if (edge_p && !send_q) begin
						rx_sh_q <= {rx_sh_q[14:0], sdi_s2_q};
					end
					if (end_p) begin
						bit_no_q <= bit_no_q + 5'h01;
						tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
						if (last_w) begin
							state_q <= ST_IDLE;
							if (!send_q) begin
								rxd_q <= rx_sh_q;
							end
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= INIT_RST;
			sdo_q  <= 1'b0;
			oe_q   <= 1'b0;
		end else if (start_w) begin
			sclk_q <= inact;
			sdo_q  <= wdata_q[CTRL_SEND] & tx_ld[15];
			oe_q   <= wdata_q[CTRL_SEND];
		end else if (busy_w) begin
			if (edge_p) begin
				sclk_q <= ~inact;
			end
			if (end_p) begin
				sclk_q <= inact;
				sdo_q  <= send_q && !last_w && tx_sh_q[14];
				oe_q   <= send_q && !last_w;
			end
		end else begin
			sclk_q <= used_q ? inact : cfg_init_q;
			sdo_q  <= 1'b0;
			oe_q   <= 1'b0;
		end
	end

	// clock pin and adjacent data pin
	assign link_clk_o   = sclk_q;
	assign link_data_o  = sdo_q;
	assign link_data_oe = oe_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic       sdo_prev_q;
	logic [7:0] stable_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sdo_prev_q <= 1'b0;
			stable_q   <= 8'h00;
		end else begin
			sdo_prev_q <= sdo_q;
			if (sdo_q != sdo_prev_q || start_w) begin
				stable_q <= 8'h00;
			end else if (stable_q != 8'hff) begin
				stable_q <= stable_q + 8'h01;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	property p_rate_legal;
		(cfg_rate_q == RATE_1K) || (cfg_rate_q == RATE_10K) || (cfg_rate_q == RATE_15K);
	endproperty
	a_rate_legal: assert property (p_rate_legal) else $error("illegal rate held");

	property p_bits_range;
		cfg_bits_q != 5'h00 && xfer_bits_q != 5'h00;
	endproperty
	a_bits_range: assert property (p_bits_range) else $error("zero bit count");

	property p_start_inact;
		start_w |=> link_clk_o == $past(cfg_fall_q) && state_q == ST_SHIFT;
	endproperty
	a_start_inact: assert property (p_start_inact) else $error("clock not idle at start");

	property p_active_level;
		busy_w && edge_p |=> link_clk_o == !cfg_fall_q;
	endproperty
	a_active_level: assert property (p_active_level) else $error("wrong active level");

	property p_setup_time;
		busy_w && send_q && edge_p |-> stable_q >= SETUP_CYC[7:0] - 8'h01;
	endproperty
	a_setup_time: assert property (p_setup_time) else $error("data setup too short");

	property p_zero_tail;
		busy_w && send_q && bit_no_q >= WORD_BITS && !end_p |-> link_data_o == 1'b0;
	endproperty
	a_zero_tail: assert property (p_zero_tail) else $error("nonzero after bit 16");

	property p_msb_first;
		start_w && wdata_q[CTRL_SEND] |=> link_data_o == $past(tx_ld[15]) && link_data_oe;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

	property p_done_last;
		$rose(done_q) |-> bit_no_q == xfer_bits_q && state_q == ST_IDLE;
	endproperty
	a_done_last: assert property (p_done_last) else $error("done before last bit");

	property p_idle_clk;
		$fell(busy_w) |-> link_clk_o == cfg_fall_q ##1 link_clk_o == cfg_fall_q;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock not parked");

	property p_rx_sample;
		busy_w && !send_q && edge_p |=> rx_sh_q[0] == $past(sdi_s2_q);
	endproperty
	a_rx_sample: assert property (p_rx_sample) else $error("missed sample");

endmodule : cws_shifter

// [common/cws_pkg.sv]
// constants and types for the clocked word shifter
// Notes on behaviour
// - shift one word up to 16 bits
// - clock pin plus adjacent data pin
// - rate 1/10/15 kbps, scales with clock
// - rate accepts 1, 10, 15; default 15
// - active edge rising or falling; default rising
// - receive samples data on active edge
// - send holds data across active edge
// - receive starts with clock inactive
// - send keeps clock inactive before first bit
// - most significant bit first both ways
// - bit count 1 to 31; default 16
// - receive keeps last 16 bits only
// - send drives zeros after sixteenth bit
// - per-transfer count overrides for one transfer
// - clock pin initial level 0 or 1
// - data stable 10.8 us before active edge
// - completion reported after final bit
package cws_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned RATE_REF_HZ = 10_000_000;
	localparam int unsigned BIT_CYC_1K  = RATE_REF_HZ / (1 * 1000);
	localparam int unsigned BIT_CYC_10K = RATE_REF_HZ / (10 * 1000);
	localparam int unsigned BIT_CYC_15K = RATE_REF_HZ / (15 * 1000);
	localparam int unsigned SETUP_NS    = 10800;
	localparam int unsigned SETUP_CYC   =
		(SETUP_NS * (RATE_REF_HZ / 1_000_000) + 999) / 1000;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int unsigned ADDR_W   = 5;
	localparam logic [4:0]  OFS_CTRL = 5'h00;
	localparam logic [4:0]  OFS_CFG  = 5'h04;
	localparam logic [4:0]  OFS_TXD  = 5'h08;
	localparam logic [4:0]  OFS_RXD  = 5'h0c;
	localparam logic [4:0]  OFS_STAT = 5'h10;

	localparam int unsigned CTRL_GO      = 0;
	localparam int unsigned CTRL_SEND    = 1;
	localparam int unsigned CTRL_OVR_LSB = 8;
	localparam int unsigned CTRL_OVR_EN  = 13;
	localparam int unsigned CFG_BITS_LSB = 0;
	localparam int unsigned CFG_FALL     = 8;
	localparam int unsigned CFG_INIT     = 9;
	localparam int unsigned CFG_RATE_LSB = 16;
	localparam int unsigned STAT_BUSY    = 0;
	localparam int unsigned STAT_DONE    = 1;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [4:0] BITS_RST  = 5'h10;
	localparam logic [4:0] RATE_RST  = 5'h0f;
	localparam logic       FALL_RST  = 1'b0;
	localparam logic       INIT_RST  = 1'b0;
	localparam logic [4:0] RATE_1K   = 5'h01;
	localparam logic [4:0] RATE_10K  = 5'h0a;
	localparam logic [4:0] RATE_15K  = 5'h0f;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVE = 2'h2;

	typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} cws_state_t;

endpackage : cws_pkg

// [src/cws_bit_timer.sv]
// per-bit cycle timer giving edge and end pulses
`timescale 1ns/1ps
module cws_bit_timer (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        run,
	input  wire logic [15:0] period,
	input  wire logic [15:0] edge_at,
	output logic             edge_p,
	output logic             end_p
);
	logic [15:0] cnt_q;

	assign edge_p = run && (cnt_q == edge_at);
	assign end_p  = run && (cnt_q == period - 16'h0001);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 16'h0000;
		end else if (!run || end_p) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule : cws_bit_timer

// [bench/cws_far_logic.sv]
// shift-register logic on the far side of the link
`timescale 1ns/1ps
module cws_far_logic (
	input  wire logic        link_clk,
	input  wire logic        wire_lvl,
	input  wire logic        fall,
	input  wire logic        ld,
	input  wire logic [31:0] ld_word,
	output logic             drv_bit,
	output logic [31:0]      cap
);
	logic [31:0] sh_q = 32'h0;

	initial cap = 32'h0;

	// ----------------------------------------
	// shift on the active clock edge
	// ----------------------------------------
	// msb first
	always @(posedge ld or posedge link_clk or negedge link_clk) begin
		if (ld) begin
			sh_q = ld_word;
			cap  = 32'h0;
		end else if (link_clk != fall) begin
			cap  = {cap[30:0], wire_lvl};
			sh_q = {sh_q[30:0], 1'b0};
		end
	end

	assign drv_bit = sh_q[31];
endmodule : cws_far_logic

// [bench/tb_clocked_word_shifter.sv]
// self-checking bench for the clocked word shifter
`timescale 1ns/1ps
module tb_clocked_word_shifter;
	import cws_pkg::*;
	localparam int unsigned SLOW = 300;
	logic        core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, lclk, din, dout, doe, pbit, fall, ld;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, cap, ld_word;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	int          err_count, tests_run, n_oe, n_pre;

	// device drives the pin only while enabled
	assign din = doe ? dout : pbit;

	cws_shifter #(.BIT_CYC_SLOW(SLOW)) dut (
		.core_clk(core_clk), .rst_n(rst_n),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .link_clk_o(lclk),
		.link_data_i(din), .link_data_o(dout), .link_data_oe(doe)
	);

	cws_far_logic far (
		.link_clk(lclk), .wire_lvl(din), .fall(fall), .ld(ld), .ld_word(ld_word),
		.drv_bit(pbit), .cap(cap)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// driven cycles, and driven cycles with the clock still inactive
	always @(negedge core_clk) begin
		if (doe === 1'b1) n_oe++;
		if (doe === 1'b1 && lclk === fall) n_pre++;
	end

	// ----------------------------------------
	// bus tasks and checks
	// ----------------------------------------
	task automatic conclude;
		$display("errors %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		err_count++;
		conclude();
	endtask : hang

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bit ta, tw, tb;
		int n;
		ta = 0;
		tw = 0;
		n = 0;
		@(posedge core_clk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= d;
		bready  <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			tb = bvalid;
			if (tb) resp = bresp;
			@(posedge core_clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			n++;
			if (n > 100) hang();
		end while (!tb);
	endtask : wr

	task automatic rdr(input logic [4:0] a);
		bit ta, tr;
		int n;
		ta = 0;
		n = 0;
		@(posedge core_clk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do begin
			@(negedge core_clk);
			ta = ta | (arvalid & arready);
			tr = rvalid;
			if (tr) rd = rdata;
			if (tr) resp = rresp;
			@(posedge core_clk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			n++;
			if (n > 100) hang();
		end while (!tr);
	endtask : rdr

	task automatic cfg(input logic [4:0] rate, input logic fl, input logic [4:0] bits);
		wr(OFS_CFG, ({27'h0, rate} << CFG_RATE_LSB) | ({31'h0, fl} << CFG_FALL) | bits);
		fall <= fl;
	endtask : cfg

	task automatic go(input logic snd, input logic [4:0] n);
		logic [31:0] d;
		d = 32'h1 | ({31'h0, snd} << CTRL_SEND);
		if (n != 5'h0) d = d | ({27'h0, n} << CTRL_OVR_LSB) | (32'h1 << CTRL_OVR_EN);
		n_oe  = 0;
		n_pre = 0;
		wr(OFS_CTRL, d);
	endtask : go

	task automatic pload(input logic [31:0] w);
		@(posedge core_clk);
		ld      <= 1'b1;
		ld_word <= w;
		@(posedge core_clk);
		ld      <= 1'b0;
	endtask : pload

	task automatic wait_done;
		int n;
		n = 0;
		do begin
			rdr(OFS_STAT);
			n++;
			if (n > 20000) hang();
		end while (rd[STAT_DONE] !== 1'b1);
		chk({30'h0, rd[1:0]}, 32'h2);
	endtask : wait_done

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rdr(OFS_CFG);
		chk(rd, 32'h000f0010);
		chk({31'h0, lclk}, 32'h0);
		wr(5'h14, 32'hffffffff);
		chk({30'h0, resp}, {30'h0, RESP_SLVE});
		rdr(5'h14);
		chk(rd, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVE});
		wr(OFS_CFG, 32'h000f0210);
		@(negedge core_clk);
		chk({30'h0, lclk, doe}, 32'h2);
		cfg(5'h07, 1'b0, 5'h10);
		rdr(OFS_CFG);
		chk(rd, 32'h000f0010);
		chk({31'h0, lclk}, 32'h0);
	endtask : t_reset

	task automatic t_send;
		pload(32'h0);
		wr(OFS_TXD, 32'h0000a5c3);
		go(1'b1, 5'h0);
		wait_done();
		chk(cap, 32'h0000a5c3);
		chk(n_oe, 16 * BIT_CYC_15K);
		pload(32'h0);
		go(1'b1, 5'd20);
		wait_done();
		chk(cap, 32'h000a5c30);
		pload(32'h0);
		go(1'b1, 5'h0);
		// go while busy: receive, five-bit override, must be ignored
		wr(OFS_CTRL, 32'h00002501);
		wait_done();
		chk(cap, 32'h0000a5c3);
		chk(n_oe, 16 * BIT_CYC_15K);
		rdr(OFS_CTRL);
		chk({31'h0, rd[CTRL_SEND]}, 32'h1);
		chk({31'h0, lclk}, 32'h0);
	endtask : t_send

	task automatic t_recv;
		cfg(RATE_10K, 1'b1, 5'h10);
		pload(32'habcde000);
		go(1'b0, 5'd20);
		@(negedge core_clk);
		chk({30'h0, lclk, doe}, 32'h2);
		wait_done();
		rdr(OFS_RXD);
		chk(rd, 32'h0000bcde);
		chk(n_oe, 0);
		chk({31'h0, lclk}, 32'h1);
	endtask : t_recv

	task automatic t_rate(input logic [4:0] code, input int p);
		cfg(code, 1'b0, 5'h01);
		wr(OFS_TXD, 32'h1);
		pload(32'h0);
		go(1'b1, 5'h0);
		wait_done();
		chk(n_oe, p);
		chk(n_pre, SETUP_CYC + 1);
		chk(cap, 32'h1);
		wr(OFS_STAT, 32'h2);
		rdr(OFS_STAT);
		chk({30'h0, rd[1:0]}, 32'h0);
	endtask : t_rate

	initial begin
		rst_n     = 1'b0;
		awvalid   = 1'b0;
		awaddr    = 5'h0;
		wvalid    = 1'b0;
		wdata     = 32'h0;
		wstrb     = 4'hf;
		bready    = 1'b0;
		arvalid   = 1'b0;
		araddr    = 5'h0;
		rready    = 1'b0;
		fall      = 1'b0;
		ld        = 1'b0;
		ld_word   = 32'h0;
		err_count = 0;
		tests_run = 0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_send();
		t_recv();
		t_rate(RATE_15K, BIT_CYC_15K);
		t_rate(RATE_10K, BIT_CYC_10K);
		t_rate(RATE_1K, SLOW);
		conclude();
	end
endmodule : tb_clocked_word_shifter
